// File: rtl/flash_host.sv
`timescale 1ns/10ps
// Behaviour
// R1 - read: select and gate low, strobe and reset high, sample data lines.
// R2 - write: strobe and select low with gate high latches address and data.
// R3 - device command register has no address; host needs no map for it.
// R4 - width select high: all sixteen data lines carry the word.
// R5 - width select low: low eight lines carry data, line 15 is byte address.
// R6 - word mode address down to A0; byte mode extends to byte_lsb_address.
// R7 - after reset the device reads array without any command.
// R8 - device stays in array read until a command changes state.
// R9 - unlock bypass programs in two host writes instead of four.
// R10 - erase covers one sector, several sectors or whole array.
// R11 - autoselect reads return codes on low eight data lines.
// R12 - during program or erase reads return status on low eight lines.
// R13 - select and reset high puts device in standby, outputs high impedance.
// R14 - after standby wait full select access time before sampling data.
// R15 - deselecting does not stop a running program or erase.
// R16 - protect: elevated reset, guard high, select low, gate high, strobe low, A6.
// R17 - guard low keeps outermost boot sector protected.
// R18 - gate high disables device outputs.
// R19 - reset low aborts, tri-states, ignores cycles, returns to array read.
// R20 - device decodes pins without clock, latches command on strobe edge.
module flash_host
    import flash_host_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output flash_host_pkg::apb_resp_t apb_resp,
    output logic [18:0] address,
    output flash_host_pkg::ctl_pins_t ctl_pins,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe
);
    import flash_host_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    typedef enum {
        st_idle,
        st_setup,
        st_strobe,
        st_recover,
        st_rst_low,
        st_rst_high
    } state_t;

    state_t state;
    logic [7:0] ctrl;
    logic [18:0] addr_reg;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic [7:0] count;
    logic [15:0] sync1, sync2, sync3, data_stable;

    // ****************************************
    // apb decode
    // ****************************************
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire busy = state != st_idle;
    wire go = wr && paddr == addr_ctrl && pwdata[ctrl_go_bit] && !busy;
    wire [2:0] op_bits = pwdata[ctrl_op_lsb +: 3];
    wire ctrl_wr = wr && paddr == addr_ctrl && !busy;
    wire mapped = paddr inside {addr_ctrl, addr_addr, addr_wdata, addr_rdata,
        addr_status, addr_pins};
    wire [31:0] status_word = {30'h0, done, busy};
    wire [31:0] read_mux = paddr == addr_ctrl ? {24'h0, ctrl} :
        paddr == addr_addr ? {13'h0, addr_reg} :
        paddr == addr_wdata ? {16'h0, wdata} :
        paddr == addr_rdata ? {16'h0, rdata} :
        paddr == addr_status ? status_word :
        paddr == addr_pins ? {25'h0, ctl_pins} : 32'h0;
    assign apb_resp.prdata = read_mux;
    assign apb_resp.pready = 1'b1;
    assign apb_resp.pslverr = access && !mapped;

    // ****************************************
    // operation decode
    // ****************************************
    op_t op;
    wire byte_mode = ctrl[ctrl_byte_bit];
    wire is_read = op == op_read;
    wire is_prot = op == op_protect || op == op_unprotect;
    wire in_cycle = state == st_setup || state == st_strobe;
    // strobe rises one cycle before select and data let go, so the latch sees them held
    wire strobe_on = state == st_strobe && !is_read && count < cycle_len + 8'h04; // R2 R9
    wire gate_on = in_cycle && is_read;
    wire elevated = ctrl[ctrl_elev_bit] || (in_cycle && is_prot);
    wire [18:0] prot_addr = {addr_reg[18:sector_lsb], 5'h0, op == op_unprotect, // R16
        protect_addr_low[5:0]};
    wire [7:0] cycle_len = is_read ? access_cyc : pulse_cyc; // R14
    wire [15:0] read_word = byte_mode ? {8'h0, data_stable[7:0]} : data_stable; // R5 R11 R12

    assign ctl_pins.chip_select_n = !in_cycle; // R13 R15
    assign ctl_pins.output_gate_n = !gate_on; // R1 R2 R18
    assign ctl_pins.write_strobe_n = !strobe_on; // R2 R20
    assign ctl_pins.hw_reset_n = !(state == st_rst_low || ctrl[ctrl_hold_reset_bit]); // R19
    assign ctl_pins.elevated_reset_level = elevated; // R16
    assign ctl_pins.write_guard_n = ctrl[ctrl_guard_bit]; // R17
    assign ctl_pins.width_select_n = !byte_mode; // R4 R5
    assign address = is_prot ? prot_addr : addr_reg; // R6 R10

    // ****************************************
    // data line drive
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < data_width; i++) begin : g_dq
            if (i == 15) begin : g_top
                // line 15 carries the byte address in byte mode
                assign data_out[i] = byte_mode ? addr_reg[0] : wdata[i]; // R5 R6
                assign data_oe[i] = byte_mode ? 1'b1 : in_cycle && !is_read;
            end else if (i >= 8) begin : g_mid
                assign data_out[i] = wdata[i];
                assign data_oe[i] = in_cycle && !is_read && !byte_mode; // R5
            end else begin : g_low
                assign data_out[i] = wdata[i];
                assign data_oe[i] = in_cycle && !is_read; // R2
            end
        end
    endgenerate

    // ****************************************
    // input synchroniser
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 16'h0000;
            sync2 <= 16'h0000;
            sync3 <= 16'h0000;
            data_stable <= 16'h0000;
        end else begin
            sync1 <= data_in;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int b = 0; b < data_width; b++) begin
                if (sync2[b] == sync3[b]) begin
                    data_stable[b] <= sync3[b];
                end
            end
        end
    end

    // ****************************************
    // registers and sequencer
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= 8'h20;
            addr_reg <= 19'h0_0000;
            wdata <= 16'h0000;
        end else begin
            if (ctrl_wr) begin
                ctrl <= {pwdata[7:1], 1'b0};
            end
            if (wr && paddr == addr_addr && !busy) begin
                addr_reg <= pwdata[18:0];
            end
            if (wr && paddr == addr_wdata && !busy) begin
                wdata <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
            op <= op_read;
            count <= 8'h00;
            rdata <= 16'h0000;
            done <= 1'b0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (go) begin
                        op <= op_t'(op_bits);
                        done <= 1'b0;
                        count <= 8'h00;
                        state <= op_bits == 3'(op_reset) ? st_rst_low : st_setup;
                    end else if (wr && paddr == addr_status && pwdata[status_done_bit]) begin
                        done <= 1'b0;
                    end
                end
                st_setup: begin
                    state <= st_strobe;
                    count <= 8'h00;
                end
                st_strobe: begin
                    count <= count + 8'h01;
                    // sample after data settled through synchroniser
                    if (count >= cycle_len + 8'h04) begin
                        if (is_read) begin
                            rdata <= read_word; // R1 R7 R8
                        end
                        count <= 8'h00;
                        state <= st_recover;
                    end
                end
                st_recover: begin
                    count <= count + 8'h01;
                    if (count >= recover_cyc) begin
                        done <= 1'b1;
                        state <= st_idle;
                    end
                end
                st_rst_low: begin
                    count <= count + 8'h01;
                    if (count >= reset_pulse_cyc) begin
                        count <= 8'h00;
                        state <= st_rst_high;
                    end
                end
                st_rst_high: begin
                    count <= count + 8'h01;
                    if (count >= reset_high_cyc) begin
                        done <= 1'b1;
                        state <= st_idle;
                    end
                end
            endcase
        end
    end
endmodule : flash_host

// File: rtl/flash_host_pkg.sv
package flash_host_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] addr_ctrl = 12'h000;
    localparam logic [11:0] addr_addr = 12'h004;
    localparam logic [11:0] addr_wdata = 12'h008;
    localparam logic [11:0] addr_rdata = 12'h00C;
    localparam logic [11:0] addr_status = 12'h010;
    localparam logic [11:0] addr_pins = 12'h014;
    // ctrl fields
    localparam int ctrl_go_bit = 0;
    localparam int ctrl_op_lsb = 1;
    localparam int ctrl_byte_bit = 4;
    localparam int ctrl_guard_bit = 5;
    localparam int ctrl_hold_reset_bit = 6;
    localparam int ctrl_elev_bit = 7;
    // status fields
    localparam int status_busy_bit = 0;
    localparam int status_done_bit = 1;
    // ****************************************
    // pin geometry
    // ****************************************
    localparam int addr_width = 19;
    localparam int data_width = 16;
    localparam int sector_lsb = 12;
    localparam int protect_sel_bit = 6;
    localparam logic [18:0] protect_addr_low = 19'h0_0002;
    // ****************************************
    // timing
    // ****************************************
    localparam int clk_period_ns = 10;
    localparam int access_ns = 70;
    localparam int output_ns = 30;
    localparam int pulse_ns = 35;
    localparam int recover_ns = 20;
    localparam int reset_pulse_ns = 500;
    localparam int reset_high_ns = 50;
    localparam logic [7:0] access_cyc = 8'((access_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [7:0] output_cyc = 8'((output_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [7:0] pulse_cyc = 8'((pulse_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [7:0] recover_cyc = 8'((recover_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [7:0] reset_pulse_cyc =
        8'((reset_pulse_ns + clk_period_ns - 1) / clk_period_ns);
    localparam logic [7:0] reset_high_cyc =
        8'((reset_high_ns + clk_period_ns - 1) / clk_period_ns);
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        op_read,
        op_write,
        op_protect,
        op_unprotect,
        op_reset
    } op_t;
    typedef struct packed {
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic hw_reset_n;
        logic elevated_reset_level;
        logic write_guard_n;
        logic width_select_n;
    } ctl_pins_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_resp_t;
endpackage : flash_host_pkg

// File: tb/flash_host_chk.sv
`timescale 1ns/10ps
module flash_host_chk
    import flash_host_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [18:0] address,
    input wire flash_host_pkg::ctl_pins_t ctl_pins,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe
);
    // ****************************************
    // pin sequencing checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence sel_held;
        (!ctl_pins.chip_select_n) [*7];
    endsequence
    read_levels_a: assert property (!ctl_pins.output_gate_n |-> !ctl_pins.chip_select_n
        && ctl_pins.write_strobe_n && data_oe[14:0] == 15'h0000) else $error("bad read levels");
    write_levels_a: assert property (!ctl_pins.write_strobe_n |->
        !ctl_pins.chip_select_n && ctl_pins.output_gate_n) else $error("bad write levels");
    strobe_width_a: assert property ($fell(ctl_pins.write_strobe_n) |=>
        (!ctl_pins.write_strobe_n) [*3]) else $error("strobe too short");
    latch_stable_a: assert property ($rose(ctl_pins.write_strobe_n) |->
        $stable(address) && $stable(data_out) && data_oe[0]) else $error("moved at latch");
    no_contend_a: assert property (|data_oe[14:0] |-> ctl_pins.output_gate_n)
        else $error("host drives with gate low");
    byte_addr_a: assert property (!ctl_pins.width_select_n && !ctl_pins.chip_select_n
        |-> data_oe[15]) else $error("byte address line not driven");
    access_time_a: assert property ($fell(ctl_pins.chip_select_n) |-> sel_held)
        else $error("select released early");
    reset_idle_a: assert property (!ctl_pins.hw_reset_n |-> ctl_pins.chip_select_n)
        else $error("selected during reset");
    reset_pulse_a: assert property ($fell(ctl_pins.hw_reset_n) |=>
        (!ctl_pins.hw_reset_n) [*8]) else $error("reset pulse short");
    protect_levels_a: assert property (ctl_pins.elevated_reset_level
        && !ctl_pins.write_strobe_n |-> ctl_pins.write_guard_n && !ctl_pins.chip_select_n
        && ctl_pins.output_gate_n && address[3:0] == 4'h2) else $error("bad protect levels");
endmodule : flash_host_chk
bind flash_host flash_host_chk i_chk (.clk(clk), .reset_n(reset_n), .address(address),
    .ctl_pins(ctl_pins), .data_out(data_out), .data_oe(data_oe));

// File: tb/flash_host_test.sv
`timescale 1ns/10ps
module flash_host_test;
    import flash_host_pkg::*;
    // ****************************************
    // bench
    // ****************************************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    apb_resp_t apb_resp;
    ctl_pins_t ctl_pins;
    logic [18:0] address;
    logic [15:0] data_in, data_out, data_oe, dev_out, dev_oe;
    logic [15:0] last = '0;
    logic [31:0] rd = '0;
    logic err = 1'b0;
    int error_cnt = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    // released lines show the inverse of their last level
    assign data_in = (data_oe & data_out) | (~data_oe & dev_oe & dev_out) | (~data_oe & ~dev_oe & ~last);
    always @(posedge clk) last <= data_in;
    flash_host i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_resp(apb_resp), .address(address),
        .ctl_pins(ctl_pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    flash_model i_flash (.address(address), .ctl_pins(ctl_pins), .dq(data_in),
        .dev_out(dev_out), .dev_oe(dev_oe));
    task automatic end_sim;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // answer values taken at the falling edge half a cycle before the rising edge that ends the access
        forever begin
            @(negedge clk);
            rdy = apb_resp.pready;
            rd = apb_resp.prdata;
            err = apb_resp.pslverr;
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic run(input op_t op, input logic bm, input logic elev);
        int n;
        apb(1'b1, addr_ctrl, 32'h0000_0021 | (32'(op) << ctrl_op_lsb)
            | (32'(bm) << ctrl_byte_bit) | (32'(elev) << ctrl_elev_bit));
        rd = '0;
        for (n = 0; n < 200 && rd[status_done_bit] !== 1'b1; n++) apb(1'b0, addr_status, '0);
        if (n >= 200) error_cnt++;
        apb(1'b1, addr_status, 32'h0000_0002);
    endtask : run
    task automatic rd_at(input logic [31:0] a, input logic bm);
        apb(1'b1, addr_addr, a);
        run(op_read, bm, 1'b0);
        apb(1'b0, addr_rdata, '0);
    endtask : rd_at
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, addr_ctrl, '0);
        check("ctrl reset", rd, 32'h0000_0020);
        apb(1'b0, 12'h0FC, '0);
        check("unmapped", {rd[30:0], err}, 32'h0000_0001);
        rd_at(32'h0001_2345, 1'b0);
        check("word read", rd, 32'h0000_231F);
        rd_at(32'h0000_0000, 1'b1);
        check("byte low", rd & 32'h0000_00FF, 32'h0000_005A);
        rd_at(32'h0007_FFFF, 1'b1);
        check("byte high", rd & 32'h0000_00FF, 32'h0000_00FF);
        apb(1'b1, addr_addr, 32'h0000_0555);
        apb(1'b1, addr_wdata, 32'h0000_0090);
        run(op_write, 1'b0, 1'b0);
        check("cmd addr", 32'(i_flash.cmd_addr), 32'h0000_0555);
        check("cmd data", 32'(i_flash.cmd_data), 32'h0000_0090);
        rd_at(32'h0001_2345, 1'b0);
        check("autoselect", rd, 32'h0000_003E);
        run(op_reset, 1'b0, 1'b0);
        rd_at(32'h0001_2345, 1'b0);
        check("after reset", rd, 32'h0000_231F);
        apb(1'b1, addr_addr, 32'h0007_F000);
        for (int i = 0; i < 2; i++) begin
            run(i ? op_unprotect : op_protect, 1'b0, 1'b1);
            check("prot addr", 32'(i_flash.cmd_addr), i ? 32'h0007_F042 : 32'h0007_F002);
            check("prot level", 32'(i_flash.elev_seen), 32'h0000_0001);
        end
        end_sim();
    end
endmodule : flash_host_test

// File: tb/flash_model.sv
`timescale 1ns/10ps
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] id_code = 8'h3E // arbitrary value
)(
    input wire logic [18:0] address,
    input wire flash_host_pkg::ctl_pins_t ctl_pins,
    input wire logic [15:0] dq,
    output logic [15:0] dev_out,
    output logic [15:0] dev_oe
);
    // ****************************************
    // device behaviour
    // ****************************************
    logic autosel = 1'b0;
    logic elev_seen = 1'b0;
    logic [18:0] cmd_addr = '0;
    logic [15:0] cmd_data = '0;
    wire logic [15:0] word = {address[15:8], address[7:0] ^ 8'h5A};
    wire logic [7:0] byte_val = dq[15] ? word[15:8] : word[7:0];
    wire logic reading = !ctl_pins.chip_select_n && !ctl_pins.output_gate_n
        && ctl_pins.write_strobe_n && ctl_pins.hw_reset_n;
    assign dev_oe = !reading ? 16'h0000 : ctl_pins.width_select_n ? 16'hFFFF : 16'h00FF;
    assign dev_out = autosel ? {8'h00, id_code} :
        ctl_pins.width_select_n ? word : {8'h00, byte_val};
    always @(posedge ctl_pins.write_strobe_n or negedge ctl_pins.hw_reset_n) begin
        if (!ctl_pins.hw_reset_n && !ctl_pins.elevated_reset_level) begin
            autosel <= 1'b0;
        end else if (!ctl_pins.chip_select_n) begin
            cmd_addr <= address;
            cmd_data <= dq;
            elev_seen <= ctl_pins.elevated_reset_level && ctl_pins.write_guard_n;
            autosel <= dq[7:0] == 8'h90;
        end
    end
endmodule : flash_model
